//--- rtl/eepctl_regs.vh
`ifndef EEPCTL_REGS_VH
`define EEPCTL_REGS_VH
// Clock 40 MHz, period in ns
`define EEPCTL_CLK_NS 25
// Page load gap: next write strobe within this time (ns)
`define EEPCTL_PAGE_GAP_NS 150000
// Host keeps each gap between data bytes below the 149 us device timeout
`define EEPCTL_GAP_SAFE_NS 140000
// Strobe pulse and phase lengths in cycles
`define EEPCTL_SETUP_CYC 4'h4
`define EEPCTL_PULSE_CYC 4'h6
`define EEPCTL_HOLD_CYC 4'h4
`define EEPCTL_READ_CYC 4'hC
// Page size in bytes
`define EEPCTL_PAGE_BYTES 7'h40
// Page row address field of a 15-bit address
`define EEPCTL_ROW_HI 14
`define EEPCTL_ROW_LO 6
// Operation codes
`define EEPCTL_OP_READ 2'h0
`define EEPCTL_OP_WRITE 2'h1
`define EEPCTL_OP_PROT 2'h2
`define EEPCTL_OP_UNPROT 2'h3
// Data polling: top data bit
`define EEPCTL_TOP_BIT 7
`endif

//--- rtl/eepctl_strobe.v
`timescale 1ns/100ps
`include "eepctl_regs.vh"
// One bus cycle on the memory pins: read or write strobe
module eepctl_strobe (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire go_in,
  input wire wr_in,
  input wire [14:0] addr_in,
  input wire [7:0] wdata_in,
  input wire [7:0] pin_data_in,
  output reg done_out,
  output reg [7:0] rdata_out,
  output reg ce_n_out,
  output reg oe_n_out,
  output reg we_n_out,
  output reg [14:0] addr_out,
  output reg [7:0] data_out,
  output reg data_oe_n_out
);
  localparam S_IDLE = 4'h1;
  localparam S_SETUP = 4'h2;
  localparam S_PULSE = 4'h4;
  localparam S_HOLD = 4'h8;
  reg [3:0] st_q;
  reg [3:0] cnt_q;
  reg wr_q;
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  // Pins arrive asynchronously
  always @(posedge sys_clk_in) begin
    sync1_q <= pin_data_in;
    sync2_q <= sync1_q;
  end
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 8'h00;
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      addr_out <= 15'h0000;
      data_out <= 8'h00;
      data_oe_n_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (go_in) begin
            wr_q <= wr_in;
            addr_out <= addr_in;
            data_out <= wdata_in;
            data_oe_n_out <= ~wr_in;
            ce_n_out <= 1'b0;
            cnt_q <= `EEPCTL_SETUP_CYC;
            st_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_q == 4'h0) begin
            // Write: strobe falls after chip select (RQ8)
            we_n_out <= ~wr_q;
            // Read: select and output enable low, strobe high (RQ1)
            oe_n_out <= wr_q;
            cnt_q <= wr_q ? `EEPCTL_PULSE_CYC : `EEPCTL_READ_CYC;
            st_q <= S_PULSE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_PULSE: begin
          if (cnt_q == 4'h0) begin
            // Strobe rises first, ending the write (RQ8)
            we_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            rdata_out <= sync2_q;
            cnt_q <= `EEPCTL_HOLD_CYC;
            st_q <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_HOLD: begin
          if (cnt_q == 4'h0) begin
            ce_n_out <= 1'b1;
            data_oe_n_out <= 1'b1;
            done_out <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // eepctl_strobe

//--- rtl/eepctl_host.v
`timescale 1ns/100ps
`include "eepctl_regs.vh"
////////////////////////////////////////////////////////////////////////////
//
// Behaviour
// (RQ1) A read is made with select and output enable low, strobe high.
// (RQ2) Only some memory variants honour the protection sequences.
// (RQ3) Writing the protect command series puts the memory in protection.
// (RQ4) While protected, writes go through only behind that same series.
// (RQ5) The three protect commands are followed by at least one data byte.
// (RQ6) Protect commands and data form one page-load burst.
// (RQ7) A distinct reset series takes the memory out of protection.
// (RQ8) Writes begin at the later fall and end at the earlier rise.
// (RQ9) Every reset command write lies within page-write timing.
// (RQ10) Unprefixed writes to a protected memory are thrown away.
// (RQ11) Strobe falls are at most 150 us apart, or programming starts.
// (RQ12) A page load holds 1 to 64 bytes on one page row address.
// (RQ13) During programming the last byte reads with its top bit inverted.
module eepctl_host #(
  // Command addresses and bytes are plain defaults, set per part
  parameter [14:0] CMD_ADDR_A = 15'h0100,
  parameter [14:0] CMD_ADDR_B = 15'h0200,
  parameter [7:0] CMD_KEY_A = 8'h11,
  parameter [7:0] CMD_KEY_B = 8'h22,
  parameter [7:0] CMD_PROT = 8'h33,
  parameter [7:0] CMD_UNP_A = 8'h44,
  parameter [7:0] CMD_UNP_B = 8'h55,
  parameter [21:0] POLL_LIMIT = 22'h3FFFFF
) (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire req_in,
  input wire [1:0] op_in,
  input wire [14:0] addr_in,
  input wire [7:0] wdata_in,
  input wire last_in,
  output reg ready_out,
  output reg ack_out,
  output reg [7:0] rdata_out,
  output reg busy_out,
  output reg timeout_out,
  output reg prot_out,
  output wire ce_n_out,
  output wire oe_n_out,
  output wire we_n_out,
  output wire [14:0] addr_out,
  output wire [7:0] data_out,
  output wire data_oe_n_out,
  input wire [7:0] data_in
);
  localparam [31:0] GAP_FULL = `EEPCTL_GAP_SAFE_NS / `EEPCTL_CLK_NS;
  localparam [17:0] GAP_CYC = GAP_FULL[17:0];
  localparam S_IDLE = 6'h01;
  localparam S_CMD = 6'h02;
  localparam S_DATA = 6'h04;
  localparam S_WAIT = 6'h08;
  localparam S_POLL = 6'h10;
  localparam S_RD = 6'h20;
  ////////////////////////////////////////////////////////////////////////
  // Command series lookup
  function [22:0] cmd_word;
    input [1:0] op;
    input [2:0] idx;
    begin
      case ({op, idx})
        5'h10, 5'h18, 5'h1B: cmd_word = {CMD_ADDR_A, CMD_KEY_A};
        5'h11, 5'h19, 5'h1C: cmd_word = {CMD_ADDR_B, CMD_KEY_B};
        5'h12: cmd_word = {CMD_ADDR_A, CMD_PROT};
        5'h1A: cmd_word = {CMD_ADDR_A, CMD_UNP_A};
        5'h1D: cmd_word = {CMD_ADDR_A, CMD_UNP_B};
        default: cmd_word = {CMD_ADDR_A, CMD_KEY_A};
      endcase
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  reg [5:0] st_q;
  reg [1:0] op_q;
  reg [2:0] idx_q;
  reg [2:0] ncmd_q;
  reg [8:0] row_q;
  reg [6:0] nbytes_q;
  reg [17:0] gap_q;
  reg [21:0] poll_q;
  reg [14:0] last_addr_q;
  reg [7:0] last_data_q;
  reg go_q;
  reg pend_q;
  reg wr_q;
  reg [14:0] baddr_q;
  reg [7:0] bdata_q;
  wire done;
  wire [7:0] brdata;
  eepctl_strobe u_strobe (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .go_in(go_q),
    .wr_in(wr_q),
    .addr_in(baddr_q),
    .wdata_in(bdata_q),
    .pin_data_in(data_in),
    .done_out(done),
    .rdata_out(brdata),
    .ce_n_out(ce_n_out),
    .oe_n_out(oe_n_out),
    .we_n_out(we_n_out),
    .addr_out(addr_out),
    .data_out(data_out),
    .data_oe_n_out(data_oe_n_out)
  );
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      st_q <= S_IDLE;
      op_q <= `EEPCTL_OP_READ;
      idx_q <= 3'h0;
      ncmd_q <= 3'h0;
      row_q <= 9'h000;
      nbytes_q <= 7'h00;
      gap_q <= 18'h00000;
      poll_q <= 22'h000000;
      last_addr_q <= 15'h0000;
      last_data_q <= 8'h00;
      go_q <= 1'b0;
      pend_q <= 1'b0;
      wr_q <= 1'b0;
      baddr_q <= 15'h0000;
      bdata_q <= 8'h00;
      ready_out <= 1'b0;
      ack_out <= 1'b0;
      rdata_out <= 8'h00;
      busy_out <= 1'b0;
      timeout_out <= 1'b0;
      prot_out <= 1'b0;
    end else begin
      go_q <= 1'b0;
      ack_out <= 1'b0;
      ready_out <= 1'b0;
      // Bus cycle in flight, so no go pulse is lost
      if (go_q) begin
        pend_q <= 1'b1;
      end else if (done) begin
        pend_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          ready_out <= 1'b1;
          if (req_in && ready_out) begin
            ready_out <= 1'b0;
            busy_out <= 1'b1;
            timeout_out <= 1'b0;
            op_q <= op_in;
            idx_q <= 3'h0;
            nbytes_q <= 7'h00;
            row_q <= addr_in[`EEPCTL_ROW_HI:`EEPCTL_ROW_LO];
            if (op_in == `EEPCTL_OP_READ) begin
              wr_q <= 1'b0; // RQ1
              baddr_q <= addr_in;
              go_q <= 1'b1;
              st_q <= S_RD;
            end else if (op_in == `EEPCTL_OP_WRITE && !prot_out) begin
              st_q <= S_DATA;
            end else begin
              // Protect prefix also guards writes (RQ4)
              ncmd_q <= (op_in == `EEPCTL_OP_UNPROT) ? 3'h6 : 3'h3; // RQ7
              {baddr_q, bdata_q} <= cmd_word(
                (op_in == `EEPCTL_OP_WRITE) ? `EEPCTL_OP_PROT : op_in, 3'h0);
              op_q <= (op_in == `EEPCTL_OP_UNPROT) ? op_in : `EEPCTL_OP_PROT;
              wr_q <= 1'b1;
              go_q <= 1'b1;
              st_q <= S_CMD;
            end
          end
        end
        S_CMD: begin
          // Back-to-back commands stay inside page timing (RQ6) (RQ9)
          if (done) begin
            if (idx_q + 3'h1 == ncmd_q) begin
              gap_q <= GAP_CYC;
              if (op_q == `EEPCTL_OP_UNPROT) begin
                prot_out <= 1'b0; // RQ7
                st_q <= S_WAIT;
              end else begin
                prot_out <= 1'b1; // RQ3
                st_q <= S_DATA; // RQ5
              end
            end else begin
              idx_q <= idx_q + 3'h1;
              {baddr_q, bdata_q} <= cmd_word(op_q, idx_q + 3'h1);
              go_q <= 1'b1;
            end
          end
        end
        S_DATA: begin
          // Data bytes follow while host keeps one row (RQ12)
          if (gap_q != 18'h00000 && nbytes_q != 7'h00)
            gap_q <= gap_q - 18'h00001;
          ready_out <= !go_q && !pend_q &&
            (nbytes_q == 7'h00 || done_ok(gap_q));
          if (req_in && ready_out && op_in == `EEPCTL_OP_WRITE &&
              addr_in[`EEPCTL_ROW_HI:`EEPCTL_ROW_LO] == row_q &&
              nbytes_q != `EEPCTL_PAGE_BYTES) begin
            ready_out <= 1'b0;
            wr_q <= 1'b1;
            baddr_q <= addr_in;
            bdata_q <= wdata_in;
            last_addr_q <= addr_in;
            last_data_q <= wdata_in;
            go_q <= 1'b1;
            gap_q <= GAP_CYC; // RQ11
            nbytes_q <= nbytes_q + 7'h01;
            if (last_in || nbytes_q + 7'h01 == `EEPCTL_PAGE_BYTES) begin
              st_q <= S_WAIT;
            end
            ack_out <= 1'b1;
          end else if (nbytes_q != 7'h00 && gap_q == 18'h00000) begin
            // Host ran out of gap time; device starts programming (RQ11)
            st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Last bus cycle finished, start polling
          if (!go_q && !pend_q) begin
            poll_q <= POLL_LIMIT;
            wr_q <= 1'b0;
            baddr_q <= last_addr_q;
            go_q <= 1'b1;
            st_q <= S_POLL;
          end
        end
        S_POLL: begin
          if (done) begin
            // Inverted top bit means still programming (RQ13)
            if (brdata[`EEPCTL_TOP_BIT] == last_data_q[`EEPCTL_TOP_BIT] ||
                op_q == `EEPCTL_OP_UNPROT && nbytes_q == 7'h00) begin
              busy_out <= 1'b0;
              st_q <= S_IDLE;
            end else if (poll_q == 22'h000000) begin
              timeout_out <= 1'b1;
              busy_out <= 1'b0;
              st_q <= S_IDLE;
            end else begin
              poll_q <= poll_q - 22'h000001;
              go_q <= 1'b1;
            end
          end
        end
        S_RD: begin
          if (done) begin
            rdata_out <= brdata; // RQ1
            ack_out <= 1'b1;
            busy_out <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Enough gap left to issue another byte
  function done_ok;
    input [17:0] g;
    begin
      done_ok = (g != 18'h00000);
    end
  endfunction
endmodule // eepctl_host

//--- verification/eepctl_host_asserts.sv
`timescale 1ns/100ps
module eepctl_host_asserts (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire req_in,
  input wire [1:0] op_in,
  input wire ready_out,
  input wire ack_out,
  input wire timeout_out,
  input wire ce_n_out,
  input wire oe_n_out,
  input wire we_n_out,
  input wire [14:0] addr_out,
  input wire [7:0] data_out,
  input wire data_oe_n_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_rd_take;
    req_in && ready_out && op_in == 2'h0;
  endsequence
  sequence s_wr_two;
    !we_n_out ##1 !we_n_out;
  endsequence
  AST_READ_MODE: assert property (!oe_n_out |-> !ce_n_out && we_n_out)
    else $error("oe low outside read");
  AST_NO_FIGHT: assert property (!oe_n_out |-> data_oe_n_out)
    else $error("bus fight in read");
  AST_WR_DRIVE: assert property (!we_n_out |-> !data_oe_n_out)
    else $error("strobe without data");
  AST_WR_STABLE: assert property (s_wr_two
    |-> $stable({addr_out, data_out})) else $error("bus moved in strobe");
  AST_RST_IDLE: assert property (disable iff (1'b0)
    !nrst_in |=> ce_n_out && oe_n_out && we_n_out && data_oe_n_out)
    else $error("pins not idle in reset");
  AST_ACK_ONE: assert property (ack_out |=> !ack_out)
    else $error("ack too long");
  AST_RD_ACK: assert property (s_rd_take |-> ##[20:40] ack_out)
    else $error("read not answered");
  AST_TO_CLR: assert property (req_in && ready_out |=> !timeout_out)
    else $error("timeout not cleared");
endmodule // eepctl_host_asserts
bind eepctl_host eepctl_host_asserts u_eepctl_host_asserts (
  .sys_clk_in, .nrst_in, .req_in, .op_in, .ready_out, .ack_out,
  .timeout_out, .ce_n_out, .oe_n_out, .we_n_out, .addr_out, .data_out,
  .data_oe_n_out
);

//--- verification/eepctl_mem_model.sv
`timescale 1ns/100ps
module eepctl_mem_model #(
  parameter bit HAS_PROT = 1'b1,
  parameter [14:0] CA = 15'h0100,
  parameter [14:0] CB = 15'h0200,
  parameter [7:0] KA = 8'h11,
  parameter [7:0] KB = 8'h22,
  parameter [7:0] KP = 8'h33,
  parameter [7:0] UA = 8'h44,
  parameter [7:0] UB = 8'h55,
  parameter real T_LOAD = 149000.0,
  parameter real T_PROG = 20000.0,
  parameter int T_ACC = 200
) (
  input wire ce_n_in,
  input wire oe_n_in,
  input wire we_n_in,
  input wire [14:0] addr_in,
  input wire [7:0] dq_in,
  output wire [7:0] dq_out
);
  logic [7:0] mem [0:32767];
  logic [137:0] hist_q = '0;
  logic prot_q = 1'b0;
  logic arm_q = 1'b0;
  logic load_q = 1'b0;
  logic prog_q = 1'b0;
  logic [14:0] last_a = 15'h0000;
  logic [7:0] last_d = 8'h00;
  logic [7:0] val = 8'h00;
  realtime t_fall = 0.0;
  realtime t_end = 0.0;
  wire rd = !ce_n_in && !oe_n_in && we_n_in;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // Write starts at the later fall, restarts the page timer
  always @(negedge (ce_n_in | we_n_in)) begin
    t_fall = $realtime;
    load_q = 1'b1;
  end
  // Write ends at the earlier rise
  always @(posedge (ce_n_in | we_n_in)) begin
    hist_q = {hist_q[114:0], addr_in, dq_in};
    if (hist_q[68:0] == {CA, KA, CB, KB, CA, KP}) begin
      prot_q = HAS_PROT;
      arm_q = 1'b1;
    end else if (hist_q == {CA, KA, CB, KB, CA, UA, CA, KA, CB, KB, CA, UB})
    begin
      prot_q = 1'b0;
    end else if (!prot_q || arm_q) begin
      mem[addr_in] = dq_in;
      last_a = addr_in;
      last_d = dq_in;
    end
  end
  // Page load closes, programming runs
  always #1000 begin
    if (load_q && $realtime - t_fall >= T_LOAD) begin
      load_q = 1'b0;
      arm_q = 1'b0;
      prog_q = 1'b1;
      t_end = $realtime + T_PROG;
    end else if (prog_q && $realtime >= t_end) begin
      prog_q = 1'b0;
    end
  end
  always @* begin
    if (rd) begin
      val = ((load_q || prog_q) && addr_in == last_a) ?
        {~last_d[7], last_d[6:0]} : mem[addr_in];
    end
  end
  assign #(T_ACC) dq_out = rd ? val : ~val;
endmodule // eepctl_mem_model

//--- verification/eepctl_host_tb_top.sv
`timescale 1ns/100ps
`include "eepctl_regs.vh"
module eepctl_host_tb_top;
  localparam [8:0] ROW = 9'h0C3;
  logic sys_clk_in = 1'b0;
  logic nrst_in, req_in, last_in;
  logic [1:0] op_in;
  logic [14:0] addr_in;
  logic [7:0] wdata_in;
  wire [7:0] rdata_out, data_out, data_in, mem_dq;
  wire [14:0] addr_out;
  wire ready_out, ack_out, timeout_out, prot_out, busy_out;
  wire ce_n_out, oe_n_out, we_n_out, data_oe_n_out;
  int mismatches = 0;
  int check_count = 0;
  logic [7:0] exq [$];
  always #12.5 sys_clk_in = ~sys_clk_in;
  assign data_in = data_oe_n_out ? mem_dq : data_out;
  eepctl_host #(.POLL_LIMIT(22'h000400)) u_eepctl_host (
    .sys_clk_in, .nrst_in, .req_in, .op_in, .addr_in, .wdata_in, .last_in,
    .ready_out, .ack_out, .rdata_out, .busy_out, .timeout_out, .prot_out,
    .ce_n_out, .oe_n_out, .we_n_out, .addr_out, .data_out, .data_oe_n_out,
    .data_in
  );
  eepctl_mem_model u_eepctl_mem_model (.ce_n_in(ce_n_out), .oe_n_in(oe_n_out),
    .we_n_in(we_n_out), .addr_in(addr_out), .dq_in(data_in), .dq_out(mem_dq));
  task automatic chk(input logic [7:0] e, input logic [7:0] g, input string s);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s: exp %h got %h", $time, s, e, g);
    end
  endtask
  task automatic op(input logic [1:0] o, input logic [14:0] a,
                    input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    #2;
    req_in = 1'b1;
    op_in = o;
    addr_in = a;
    wdata_in = d;
    last_in = l;
    @(posedge sys_clk_in);
    while (ready_out !== 1'b1 && n < 40000) begin
      n++;
      @(posedge sys_clk_in);
    end
    if (o == `EEPCTL_OP_READ) exq.push_back(d);
    if (n == 40000) chk(8'h01, 8'h00, "request not taken");
    #2;
    req_in = 1'b0;
  endtask
  task automatic burst(input logic [1:0] o, input int n, input string nm);
    logic [7:0] dv [4];
    op(o, {ROW, 6'h00}, 8'h00, 1'b0);
    for (int i = 0; i < n; i++) begin
      dv[i] = 8'($urandom);
      op(`EEPCTL_OP_WRITE, {ROW, 6'(i * 21)}, dv[i], i == n - 1);
    end
    for (int i = 0; i < n; i++) begin
      op(`EEPCTL_OP_READ, {ROW, 6'(i * 21)}, dv[i], 1'b0);
    end
    $display("test %s done", nm);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Read results as they come back
  always @(posedge sys_clk_in) begin
    #1;
    if (ack_out === 1'b1 && exq.size() > 0) begin
      chk(exq.pop_front(), rdata_out, "read data");
    end
  end
  initial begin
    nrst_in = 1'b0;
    req_in = 1'b0;
    op_in = 2'h0;
    addr_in = 15'h0000;
    wdata_in = 8'h00;
    last_in = 1'b0;
    void'($urandom(950));
    repeat (8) @(posedge sys_clk_in);
    #2;
    nrst_in = 1'b1;
    chk(8'h0F, 8'({ce_n_out, oe_n_out, we_n_out, data_oe_n_out}), "idle");
    chk(8'h00, 8'(prot_out), "prot at reset");
    burst(`EEPCTL_OP_WRITE, 4, "page");
    burst(`EEPCTL_OP_PROT, 2, "protect");
    chk(8'h01, 8'(prot_out), "host prot");
    chk(8'h01, 8'(u_eepctl_mem_model.prot_q), "mem prot");
    burst(`EEPCTL_OP_WRITE, 1, "locked");
    op(`EEPCTL_OP_UNPROT, 15'h0000, 8'h00, 1'b1);
    burst(`EEPCTL_OP_WRITE, 3, "open");
    chk(8'h00, 8'(prot_out), "host unprot");
    chk(8'h00, 8'(u_eepctl_mem_model.prot_q), "mem unprot");
    repeat (40) @(posedge sys_clk_in);
    chk(8'h00, 8'(timeout_out), "poll timeout");
    chk(8'h00, 8'(busy_out), "busy at end");
    chk(8'h00, 8'(exq.size()), "reads left");
    finish_test;
  end
  initial begin
    #(25 * 90000);
    chk(8'h01, 8'h00, "watchdog");
    finish_test;
  end
endmodule // eepctl_host_tb_top
